// ===== core/arf_core_regs.sv
`timescale 1ns/1ps
`default_nettype none
module arf_core_regs #(
	parameter int GP_COUNT = arf_pkg::GP_COUNT
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	// Register port
	input  wire logic [5:0]            regAddr,
	input  wire logic [31:0]           regWdata,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic [31:0]                regRdata,
	// Mode and privilege
	input  wire logic                  protMode,
	input  wire logic [1:0]            current_priv_level,
	input  wire logic                  addr16,
	// Instruction boundary
	input  wire logic                  instrDone,
	input  wire logic                  instrFault,
	input  wire logic [31:0]           nextOffset,
	input  wire logic                  privOpcode,
	input  wire logic                  ioInstr,
	input  wire logic                  stringStep,
	input  wire logic [2:0]            stringStepSize,
	input  wire logic                  bkptMatch,
	// Flag image operations
	input  wire arf_pkg::arf_fpop_e    flagOp,
	input  wire logic [31:0]           flagImage,
	input  wire logic                  taskNested,
	// Arithmetic
	input  wire arf_pkg::arf_alu_req_s aluReq,
	input  wire logic [2:0]            aluDest,
	// Segments
	input  wire logic                  segLoad,
	input  wire logic [2:0]            segIdx,
	input  wire logic [15:0]           segSel,
	input  wire arf_pkg::arf_desc_s    segDesc,
	input  wire arf_pkg::arf_mem_req_s memReq,
	// Events
	input  wire logic                  ext_irq_pin,
	output logic                       irqTake,
	output logic                       excRaise,
	output logic [7:0]                 excVector,
	output logic                       ioBitmapCheck,
	output logic [31:0]                flagPushImage,
	output logic [31:0]                flagSaveImage,
	output logic                       nestedReturn,
	output logic [31:0]                linearAddr,
	output logic                       limitFault,
	output logic [31:0]                fetchOffset
);
	localparam int IXW = $clog2(GP_COUNT);

	function automatic logic [31:0] mergeWrite(input logic [31:0] old, input logic [5:0] a,
			input logic [31:0] wd);
		if (a < arf_pkg::ADR_GP16)
			mergeWrite = wd;
		else if (a < arf_pkg::ADR_GP8LO)
			mergeWrite = {old[31:16], wd[15:0]};
		else if (a < arf_pkg::ADR_GP8HI)
			mergeWrite = {old[31:8], wd[7:0]};
		else
			mergeWrite = {old[31:16], wd[7:0], old[7:0]};
	endfunction : mergeWrite

	function automatic logic [31:0] cleanFlags(input logic [31:0] f);
		cleanFlags = (f & 32'h0003_7fd5) | arf_pkg::FLAG_FIXED1;
	endfunction : cleanFlags

	logic [31:0] gp_q [GP_COUNT];
	logic [31:0] gp_d [GP_COUNT];
	logic [31:0] ip_q, ip_d;
	logic [31:0] fl_q, fl_d;
	logic [31:0] rd_q, rd_d;
	logic        resumeArm_q, resumeArm_d;

	logic [31:0]        aluResult;
	logic [5:0]         aluFlags;
	logic [15:0]        selView [arf_pkg::SEG_COUNT];
	arf_pkg::arf_desc_s descView [arf_pkg::SEG_COUNT];
	logic               legacyActive;
	logic               fullPriv;
	logic               ifAllowed;
	logic [IXW-1:0]     wIdx;
	logic [31:0]        stepAmt;

	arf_flag_calc uFlags (
		.req    (aluReq),
		.result (aluResult),
		.flags  (aluFlags)
	);

	for (genvar s = 0; s < arf_pkg::SEG_COUNT; s++) begin : gSeg
		arf_seg_unit uSeg (
			.ref_clk    (ref_clk),
			.rst_n      (rst_n),
			.load       ((segLoad && segIdx == 3'(s)) ||
			             (regWr && regAddr == arf_pkg::ADR_SEL + 6'(s))),
			.selIn      (segLoad ? segSel : regWdata[15:0]),
			.protMode   (protMode),
			.legacyMode (legacyActive),
			.descIn     (segDesc),
			.resetSel   ((s == 0) ? arf_pkg::CODE_SEL_RESET : 16'h0),
			.resetBase  ((s == 0) ? {12'h0, arf_pkg::CODE_SEL_RESET, 4'h0} : 32'h0),
			.sel        (selView[s]),
			.desc       (descView[s])
		);
	end

	assign legacyActive = protMode & fl_q[arf_pkg::FL_LEGACY];
	assign fullPriv = (current_priv_level == 2'h0);
	assign ifAllowed = !protMode || (current_priv_level <= fl_q[arf_pkg::FL_IO_PRIV_LEVEL_LO +: 2]);
	assign wIdx = regAddr[IXW-1:0];

	always_comb begin
		for (int i = 0; i < GP_COUNT; i++)
			gp_d[i] = gp_q[i];
		ip_d = ip_q;
		fl_d = fl_q;
		rd_d = 32'h0;
		resumeArm_d = resumeArm_q;
		stepAmt = {29'h0, stringStepSize};
		if (aluReq.valid) begin
			gp_d[aluDest] = (aluReq.width == arf_pkg::W32) ? aluResult
				: (aluReq.width == arf_pkg::W16) ? {gp_q[aluDest][31:16], aluResult[15:0]}
				: {gp_q[aluDest][31:8], aluResult[7:0]};
			fl_d[arf_pkg::FL_CARRY] = aluFlags[0];
			fl_d[arf_pkg::FL_PARITY] = aluFlags[1];
			fl_d[arf_pkg::FL_NIBBLE] = aluFlags[2];
			fl_d[arf_pkg::FL_ZERO] = aluFlags[3];
			fl_d[arf_pkg::FL_SIGN] = aluFlags[4];
			fl_d[arf_pkg::FL_OVF] = aluFlags[5];
		end
		if (stringStep) begin
			if (fl_q[arf_pkg::FL_DIR]) begin
				gp_d[4] = gp_q[4] - stepAmt;
				gp_d[5] = gp_q[5] - stepAmt;
			end else begin
				gp_d[4] = gp_q[4] + stepAmt;
				gp_d[5] = gp_q[5] + stepAmt;
			end
		end
		if (instrDone && !instrFault) begin
			ip_d = addr16 ? {16'h0, nextOffset[15:0]} : nextOffset;
			resumeArm_d = fl_q[arf_pkg::FL_RESUME];
			fl_d[arf_pkg::FL_RESUME] = 1'b0;
		end
		case (flagOp)
			arf_pkg::FP_POP: begin
				fl_d[15:0] = flagImage[15:0];
				fl_d[arf_pkg::FL_RESUME] = flagImage[arf_pkg::FL_RESUME];
				fl_d[arf_pkg::FL_NEST] = flagImage[arf_pkg::FL_NEST];
				if (!fullPriv)
					fl_d[arf_pkg::FL_IO_PRIV_LEVEL_LO +: 2] = fl_q[arf_pkg::FL_IO_PRIV_LEVEL_LO +: 2];
				if (!ifAllowed)
					fl_d[arf_pkg::FL_IRQEN] = fl_q[arf_pkg::FL_IRQEN];
				fl_d[arf_pkg::FL_LEGACY] = fl_q[arf_pkg::FL_LEGACY];
			end
			arf_pkg::FP_INTERRUPT_RETURN_INSTR: begin
				fl_d = flagImage;
				fl_d[arf_pkg::FL_NEST] = flagImage[arf_pkg::FL_NEST];
				if (!fullPriv)
					fl_d[arf_pkg::FL_IO_PRIV_LEVEL_LO +: 2] = fl_q[arf_pkg::FL_IO_PRIV_LEVEL_LO +: 2];
				if (!ifAllowed)
					fl_d[arf_pkg::FL_IRQEN] = fl_q[arf_pkg::FL_IRQEN];
				if (!(protMode && fullPriv))
					fl_d[arf_pkg::FL_LEGACY] = fl_q[arf_pkg::FL_LEGACY];
			end
			arf_pkg::FP_TASK: begin
				fl_d = flagImage;
				fl_d[arf_pkg::FL_NEST] = taskNested;
				if (!protMode)
					fl_d[arf_pkg::FL_LEGACY] = fl_q[arf_pkg::FL_LEGACY];
			end
			arf_pkg::FP_INTENTRY: begin
				fl_d[arf_pkg::FL_STEP] = 1'b0;
				fl_d[arf_pkg::FL_IRQEN] = 1'b0;
				fl_d[arf_pkg::FL_NEST] = 1'b0;
				fl_d[arf_pkg::FL_LEGACY] = 1'b0;
			end
			default: ;
		endcase
		if (flagOp != arf_pkg::FP_NONE)
			fl_d = cleanFlags(fl_d);
		if (regWr) begin
			if (regAddr < arf_pkg::ADR_GP8LO)
				gp_d[wIdx] = mergeWrite(gp_q[wIdx], regAddr, regWdata);
			else if (regAddr < arf_pkg::ADR_IP)
				gp_d[regAddr[1:0]] = mergeWrite(gp_q[regAddr[1:0]], regAddr, regWdata);
			else if (regAddr == arf_pkg::ADR_IP)
				ip_d = regWdata;
			else if (regAddr == arf_pkg::ADR_FLAGS)
				fl_d = cleanFlags(regWdata);
		end
		if (regRd) begin
			if (regAddr < arf_pkg::ADR_GP16)
				rd_d = gp_q[wIdx];
			else if (regAddr < arf_pkg::ADR_GP8LO)
				rd_d = {16'h0, gp_q[wIdx][15:0]};
			else if (regAddr < arf_pkg::ADR_GP8HI)
				rd_d = {24'h0, gp_q[regAddr[1:0]][7:0]};
			else if (regAddr < arf_pkg::ADR_IP)
				rd_d = {24'h0, gp_q[regAddr[1:0]][15:8]};
			else if (regAddr == arf_pkg::ADR_IP)
				rd_d = ip_q;
			else if (regAddr == arf_pkg::ADR_FLAGS)
				rd_d = fl_q;
			else if (regAddr == arf_pkg::ADR_STAT)
				rd_d = {28'h0, resumeArm_q, legacyActive, protMode, limitFault};
			else if (regAddr >= arf_pkg::ADR_SEL && regAddr < arf_pkg::ADR_SEL + 6'h6)
				rd_d = {16'h0, selView[3'(regAddr - arf_pkg::ADR_SEL)]};
			else if (regAddr >= arf_pkg::ADR_BASE && regAddr < arf_pkg::ADR_BASE + 6'h6)
				rd_d = descView[3'(regAddr - arf_pkg::ADR_BASE)].base;
			else if (regAddr >= arf_pkg::ADR_LIMIT && regAddr < arf_pkg::ADR_LIMIT + 6'h6)
				rd_d = descView[3'(regAddr - arf_pkg::ADR_LIMIT)].limit;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < GP_COUNT; i++)
				gp_q[i] <= 32'h0;
			ip_q <= arf_pkg::IP_RESET;
			fl_q <= arf_pkg::FLAG_RESET;
			rd_q <= 32'h0;
			resumeArm_q <= 1'b0;
		end else begin
			for (int i = 0; i < GP_COUNT; i++)
				gp_q[i] <= gp_d[i];
			ip_q <= ip_d;
			fl_q <= fl_d;
			rd_q <= rd_d;
			resumeArm_q <= resumeArm_d;
		end
	end

	assign regRdata = rd_q;
	assign fetchOffset = addr16 ? {16'h0, ip_q[15:0]} : ip_q;

	// Pushed image never carries the legacy bit; saved image marks legacy task
	assign flagPushImage = fl_q & ~(32'h1 << arf_pkg::FL_LEGACY);
	assign flagSaveImage = fl_q | ({31'h0, legacyActive} << arf_pkg::FL_LEGACY);
	assign nestedReturn = (flagOp == arf_pkg::FP_INTERRUPT_RETURN_INSTR) & protMode & fl_q[arf_pkg::FL_NEST];

	assign irqTake = ext_irq_pin & fl_q[arf_pkg::FL_IRQEN];

	always_comb begin
		excRaise = 1'b0;
		excVector = 8'h0;
		// Bitmap lookup is not a fault, so it never hides a step trap
		ioBitmapCheck = instrDone && ioInstr && protMode &&
			(current_priv_level > fl_q[arf_pkg::FL_IO_PRIV_LEVEL_LO +: 2]);
		if (instrDone && legacyActive && privOpcode) begin
			excRaise = 1'b1;
			excVector = arf_pkg::EXC_GPF;
		end else if (instrDone && fl_q[arf_pkg::FL_STEP]) begin
			excRaise = 1'b1;
			excVector = arf_pkg::EXC_DEBUG;
		end else if (bkptMatch && !resumeArm_q) begin
			excRaise = 1'b1;
			excVector = arf_pkg::EXC_DEBUG;
		end
	end

	// Byte views are never used here; memReq.offset, the segment base, limit and attr bits and the write/exec request flags feed addressing
	always_comb begin
		linearAddr = descView[memReq.seg].base + memReq.offset;
		limitFault = memReq.valid && ((memReq.offset > descView[memReq.seg].limit) ||
			(memReq.isWrite && !descView[memReq.seg].attr[1]) ||
			(memReq.isExec && !descView[memReq.seg].attr[3]));
	end
endmodule : arf_core_regs
`default_nettype wire

// ===== core/arf_flag_calc.sv
`timescale 1ns/1ps
`default_nettype none
module arf_flag_calc (
	input  wire arf_pkg::arf_alu_req_s req,
	output logic [31:0]                result,
	output logic [5:0]                 flags
);
	function automatic logic topBit(input logic [31:0] v, input arf_pkg::arf_width_e w);
		case (w)
			arf_pkg::W8:  topBit = v[7];
			arf_pkg::W16: topBit = v[15];
			default:      topBit = v[31];
		endcase
	endfunction : topBit

	logic [32:0] sum;
	logic [31:0] bOp;
	logic [31:0] carries;
	logic [31:0] masked;
	logic        cOut;
	logic        cInto;
	logic        isArith;

	always_comb begin
		isArith = (req.kind != arf_pkg::OP_LOGIC);
		bOp = (req.kind == arf_pkg::OP_SUB) ? ~req.b : req.b;
		sum = {1'b0, req.a} + {1'b0, bOp} + {32'h0, (req.kind == arf_pkg::OP_SUB) ^ req.carryIn};
		carries = req.a ^ bOp ^ sum[31:0];
		case (req.width)
			arf_pkg::W8: begin
				masked = {24'h0, sum[7:0]};
				cOut = carries[8];
				cInto = carries[7];
			end
			arf_pkg::W16: begin
				masked = {16'h0, sum[15:0]};
				cOut = (req.a[15] & bOp[15]) | (carries[15] & (req.a[15] ^ bOp[15]));
				cInto = carries[15];
			end
			default: begin
				masked = sum[31:0];
				cOut = sum[32];
				cInto = carries[31];
			end
		endcase
		result = isArith ? masked : req.a;
		// carry_out_bit: borrow is inverted carry on subtract
		flags[0] = isArith & (cOut ^ (req.kind == arf_pkg::OP_SUB));
		flags[1] = ~^result[7:0];
		// Inverted operand flips the bit-4 carry on subtract
		flags[2] = isArith & (carries[4] ^ (req.kind == arf_pkg::OP_SUB));
		flags[3] = (result == 32'h0);
		flags[4] = topBit(result, req.width);
		flags[5] = isArith & (cInto ^ cOut);
	end
endmodule : arf_flag_calc
`default_nettype wire

// ===== core/arf_pkg.sv
package arf_pkg;
	localparam int GP_COUNT = 8;
	localparam int SEG_COUNT = 6;
	// Flag word bit positions
	localparam int FL_CARRY = 0;
	localparam int FL_PARITY = 2;
	localparam int FL_NIBBLE = 4;
	localparam int FL_ZERO = 6;
	localparam int FL_SIGN = 7;
	localparam int FL_STEP = 8;
	localparam int FL_IRQEN = 9;
	localparam int FL_DIR = 10;
	localparam int FL_OVF = 11;
	localparam int FL_IO_PRIV_LEVEL_LO = 12;
	localparam int FL_NEST = 14;
	localparam int FL_RESUME = 16;
	localparam int FL_LEGACY = 17;
	localparam logic [31:0] FLAG_RESET = 32'h0000_0002;
	localparam logic [31:0] FLAG_FIXED1 = 32'h0000_0002;
	localparam logic [31:0] IP_RESET = 32'h0000_fff0;
	localparam logic [15:0] CODE_SEL_RESET = 16'hf000;
	localparam logic [31:0] REAL_LIMIT = 32'h0000_ffff;
	localparam logic [11:0] REAL_ATTR = 12'h093;
	localparam logic [7:0] EXC_DEBUG = 8'h01;
	localparam logic [7:0] EXC_GPF = 8'h0d;
	// Register port address map
	localparam logic [5:0] ADR_GP32 = 6'h00;
	localparam logic [5:0] ADR_GP16 = 6'h08;
	localparam logic [5:0] ADR_GP8LO = 6'h10;
	localparam logic [5:0] ADR_GP8HI = 6'h14;
	localparam logic [5:0] ADR_IP = 6'h18;
	localparam logic [5:0] ADR_FLAGS = 6'h19;
	localparam logic [5:0] ADR_STAT = 6'h1a;
	localparam logic [5:0] ADR_SEL = 6'h20;
	localparam logic [5:0] ADR_BASE = 6'h28;
	localparam logic [5:0] ADR_LIMIT = 6'h30;

	typedef enum logic [1:0] {W8, W16, W32} arf_width_e;
	typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_LOGIC} arf_alu_e;
	typedef enum logic [2:0] {
		FP_NONE, FP_POP, FP_INTERRUPT_RETURN_INSTR, FP_TASK, FP_INTENTRY
	} arf_fpop_e;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
		logic [11:0] attr;
	} arf_desc_s;

	typedef struct packed {
		logic        valid;
		arf_alu_e    kind;
		arf_width_e  width;
		logic [31:0] a;
		logic [31:0] b;
		logic        carryIn;
	} arf_alu_req_s;

	typedef struct packed {
		logic        valid;
		logic [2:0]  seg;
		logic [31:0] offset;
		logic        isWrite;
		logic        isExec;
	} arf_mem_req_s;
endpackage : arf_pkg

// ===== core/arf_seg_unit.sv
`timescale 1ns/1ps
`default_nettype none
module arf_seg_unit (
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                load,
	input  wire logic [15:0]         selIn,
	input  wire logic                protMode,
	input  wire logic                legacyMode,
	input  wire arf_pkg::arf_desc_s  descIn,
	input  wire logic [15:0]         resetSel,
	input  wire logic [31:0]         resetBase,
	output logic [15:0]              sel,
	output arf_pkg::arf_desc_s       desc
);
	logic [15:0]        sel_q, sel_d;
	arf_pkg::arf_desc_s desc_q, desc_d;
	logic               fresh_q, fresh_d;

	always_comb begin
		sel_d = sel_q;
		desc_d = desc_q;
		fresh_d = fresh_q;
		if (load) begin
			fresh_d = 1'b0;
			sel_d = selIn;
			if (protMode && !legacyMode) begin
				desc_d = descIn;
			end else begin
				desc_d.base = {12'h0, selIn, 4'h0};
				desc_d.limit = arf_pkg::REAL_LIMIT;
				desc_d.attr = arf_pkg::REAL_ATTR;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q <= 16'h0;
			desc_q <= '{base: 32'h0, limit: arf_pkg::REAL_LIMIT, attr: arf_pkg::REAL_ATTR};
			fresh_q <= 1'b1;
		end else begin
			sel_q <= sel_d;
			desc_q <= desc_d;
			fresh_q <= fresh_d;
		end
	end

	// Reset contents shown until the first load, so a later zero load stays zero
	assign sel = fresh_q ? resetSel : sel_q;
	assign desc = fresh_q
		? '{base: resetBase, limit: desc_q.limit, attr: desc_q.attr} : desc_q;
endmodule : arf_seg_unit
`default_nettype wire

// ===== testbench/arf_core_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module arf_core_regs_props (
	input wire logic               ref_clk,
	input wire logic               rst_n,
	input wire logic               protMode,
	input wire logic [1:0]         current_priv_level,
	input wire logic               addr16,
	input wire logic               instrDone,
	input wire logic               instrFault,
	input wire logic               privOpcode,
	input wire logic               bkptMatch,
	input wire logic               regWr,
	input wire arf_pkg::arf_fpop_e flagOp,
	input wire logic               ext_irq_pin,
	input wire logic               irqTake,
	input wire logic               excRaise,
	input wire logic [7:0]         excVector,
	input wire logic               ioBitmapCheck,
	input wire logic [31:0]        flagPushImage,
	input wire logic [31:0]        flagSaveImage,
	input wire logic               nestedReturn,
	input wire logic [31:0]        fetchOffset
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_clean;
		instrDone && !instrFault && !privOpcode && flagOp == arf_pkg::FP_NONE && !regWr;
	endsequence
	sequence s_debug;
		excRaise && excVector == arf_pkg::EXC_DEBUG;
	endsequence
	property p_irq; irqTake |-> ext_irq_pin && flagPushImage[arf_pkg::FL_IRQEN]; endproperty
	a_irq: assert property (p_irq) else $error("interrupt taken while disabled");
	property p_push_legacy; flagPushImage[arf_pkg::FL_LEGACY] == 1'b0; endproperty
	a_push_legacy: assert property (p_push_legacy) else $error("push image legacy bit set");
	property p_step; s_clean ##0 flagPushImage[arf_pkg::FL_STEP] |-> s_debug; endproperty
	a_step: assert property (p_step) else $error("no step trap");
	property p_dbg_cause; s_debug |-> flagPushImage[arf_pkg::FL_STEP] || bkptMatch; endproperty
	a_dbg_cause: assert property (p_dbg_cause) else $error("debug trap without cause");
	property p_legacy_priv;
		instrDone && privOpcode && protMode && flagSaveImage[arf_pkg::FL_LEGACY]
			|-> excRaise && excVector == arf_pkg::EXC_GPF;
	endproperty
	a_legacy_priv: assert property (p_legacy_priv) else $error("privileged op not faulted");
	property p_io; ioBitmapCheck |-> protMode && current_priv_level > flagPushImage[13:12]; endproperty
	a_io: assert property (p_io) else $error("bitmap consulted within io level");
	property p_nest; nestedReturn |-> flagOp == arf_pkg::FP_INTERRUPT_RETURN_INSTR && flagPushImage[arf_pkg::FL_NEST]; endproperty
	a_nest: assert property (p_nest) else $error("nested return without link");
	property p_resume_clr; s_clean |=> !flagSaveImage[arf_pkg::FL_RESUME]; endproperty
	a_resume_clr: assert property (p_resume_clr) else $error("suppress flag not cleared");
	property p_ip16; addr16 |-> fetchOffset[31:16] == 16'h0000; endproperty
	a_ip16: assert property (p_ip16) else $error("offset upper half in 16-bit mode");
	property p_save_low; flagSaveImage[15:0] == flagPushImage[15:0]; endproperty
	a_save_low: assert property (p_save_low) else $error("saved image differs");
endmodule : arf_core_regs_props

bind arf_core_regs arf_core_regs_props u_props (.ref_clk, .rst_n, .protMode, .current_priv_level, .addr16,
	.instrDone, .instrFault, .privOpcode, .bkptMatch, .regWr, .flagOp, .ext_irq_pin, .irqTake, .excRaise,
	.excVector, .ioBitmapCheck, .flagPushImage, .flagSaveImage, .nestedReturn, .fetchOffset);
`default_nettype wire

// ===== testbench/tb_arf_core_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_arf_core_regs;
	typedef struct {
		arf_pkg::arf_alu_e   k;
		arf_pkg::arf_width_e w;
		logic [31:0]         a, b, res, fl;
	} arf_row_s;
	logic ref_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, protMode = 1'b0, addr16 = 1'b0;
	logic instrDone = 1'b0, instrFault = 1'b0, privOpcode = 1'b0, ioInstr = 1'b0, stringStep = 1'b0;
	logic bkptMatch = 1'b0, taskNested = 1'b0, segLoad = 1'b0, ext_irq_pin = 1'b0;
	logic [5:0]              regAddr = 6'h00;
	logic [31:0]             regWdata = 32'h0, nextOffset = 32'h0, flagImage = 32'h0;
	logic [1:0]              current_priv_level = 2'h0;
	logic [2:0]              stringStepSize = 3'h0, aluDest = 3'h0, segIdx = 3'h0;
	logic [15:0]             segSel = 16'h0;
	arf_pkg::arf_fpop_e      flagOp = arf_pkg::FP_NONE;
	arf_pkg::arf_alu_req_s   aluReq = '0;
	arf_pkg::arf_desc_s      segDesc = '0;
	arf_pkg::arf_mem_req_s   memReq = '0;
	logic [31:0]             regRdata, flagPushImage, flagSaveImage, linearAddr, fetchOffset, v, sx, msk;
	logic                    irqTake, excRaise, ioBitmapCheck, nestedReturn, limitFault, snr;
	logic [7:0]              excVector;
	int                      err_count = 0, checked = 0;
	arf_row_s rows [7] = '{
		'{arf_pkg::OP_ADD, arf_pkg::W8, 32'h7f, 32'h01, 32'h80, 32'h890},
		'{arf_pkg::OP_ADD, arf_pkg::W16, 32'hffff, 32'h01, 32'h0, 32'h55},
		'{arf_pkg::OP_SUB, arf_pkg::W32, 32'h0, 32'h01, 32'hffffffff, 32'h95},
		'{arf_pkg::OP_SUB, arf_pkg::W32, 32'h80000000, 32'h01, 32'h7fffffff, 32'h814},
		'{arf_pkg::OP_ADD, arf_pkg::W32, 32'h03, 32'h04, 32'h07, 32'h0},
		'{arf_pkg::OP_SUB, arf_pkg::W8, 32'h10, 32'h10, 32'h0, 32'h44},
		'{arf_pkg::OP_ADD, arf_pkg::W8, 32'h80, 32'h80, 32'h0, 32'h845}
	};

	arf_core_regs dut (.ref_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .protMode,
		.current_priv_level, .addr16, .instrDone, .instrFault, .nextOffset, .privOpcode, .ioInstr,
		.stringStep, .stringStepSize, .bkptMatch, .flagOp, .flagImage, .taskNested, .aluReq, .aluDest,
		.segLoad, .segIdx, .segSel, .segDesc, .memReq, .ext_irq_pin, .irqTake, .excRaise, .excVector,
		.ioBitmapCheck, .flagPushImage, .flagSaveImage, .nestedReturn, .linearAddr, .limitFault, .fetchOffset);

	always #2 ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		v = regRdata;
	endtask : rd
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		rd(a);
		chk(v, e);
	endtask : rdc
	task automatic step(input logic [2:0] sz);
		@(posedge ref_clk);
		stringStep <= 1'b1;
		stringStepSize <= sz;
		@(posedge ref_clk);
		stringStep <= 1'b0;
	endtask : step
	task automatic fop(input arf_pkg::arf_fpop_e op, input logic [31:0] img);
		@(posedge ref_clk);
		flagOp <= op;
		flagImage <= img;
		#1;
		snr = nestedReturn;
		@(posedge ref_clk);
		flagOp <= arf_pkg::FP_NONE;
	endtask : fop
	task automatic done(input logic p, input logic io, input logic [31:0] off);
		@(posedge ref_clk);
		instrDone <= 1'b1;
		privOpcode <= p;
		ioInstr <= io;
		nextOffset <= off;
		#1;
		sx = {22'h0, ioBitmapCheck, excRaise, excVector};
		@(posedge ref_clk);
		instrDone <= 1'b0;
	endtask : done
	task automatic seg(input logic [2:0] i, input logic [15:0] s, input logic [31:0] b, input logic [31:0] l);
		@(posedge ref_clk);
		segLoad <= 1'b1;
		segIdx <= i;
		segSel <= s;
		segDesc <= '{b, l, arf_pkg::REAL_ATTR};
		@(posedge ref_clk);
		segLoad <= 1'b0;
	endtask : seg
	task automatic mem(input logic [2:0] i, input logic [31:0] off, input logic [31:0] lin, input logic f);
		@(posedge ref_clk);
		memReq <= '{1'b1, i, off, 1'b0, 1'b0};
		#1;
		chk(linearAddr, lin);
		chk({31'h0, limitFault}, {31'h0, f});
		@(posedge ref_clk);
		memReq.valid <= 1'b0;
	endtask : mem
	task automatic wrap_up();
		if (err_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdc(arf_pkg::ADR_FLAGS, arf_pkg::FLAG_RESET);
		rdc(arf_pkg::ADR_IP, arf_pkg::IP_RESET);
		rdc(arf_pkg::ADR_BASE, {12'h0, arf_pkg::CODE_SEL_RESET, 4'h0});
		rdc(arf_pkg::ADR_LIMIT + 6'h2, arf_pkg::REAL_LIMIT);
		rdc(6'h3f, 32'h0);
		foreach (rows[i]) begin
			@(posedge ref_clk);
			aluReq <= '{1'b1, rows[i].k, rows[i].w, rows[i].a, rows[i].b, 1'b0};
			aluDest <= 3'(i);
			@(posedge ref_clk);
			aluReq.valid <= 1'b0;
			msk = rows[i].w == arf_pkg::W8 ? 32'hff : rows[i].w == arf_pkg::W16 ? 32'hffff : 32'hffffffff;
			rd(arf_pkg::ADR_GP32 + 6'(i));
			chk(v & msk, rows[i].res);
			rd(arf_pkg::ADR_FLAGS);
			chk(v & 32'h8d5, rows[i].fl);
		end
		wr(arf_pkg::ADR_GP32 + 6'h2, 32'h11223344);
		wr(arf_pkg::ADR_GP16 + 6'h2, 32'h0000aaaa);
		wr(arf_pkg::ADR_GP8HI + 6'h2, 32'h00000055);
		wr(arf_pkg::ADR_GP8LO + 6'h2, 32'h00000066);
		rdc(arf_pkg::ADR_GP32 + 6'h2, 32'h11225566);
		rdc(arf_pkg::ADR_GP16 + 6'h2, 32'h00005566);
		rdc(arf_pkg::ADR_GP8HI + 6'h2, 32'h00000055);
		wr(arf_pkg::ADR_GP32 + 6'h4, 32'h00000100);
		wr(arf_pkg::ADR_GP32 + 6'h5, 32'h00000200);
		step(3'h4);
		rdc(arf_pkg::ADR_GP32 + 6'h4, 32'h00000104);
		wr(arf_pkg::ADR_FLAGS, 32'h00000402);
		step(3'h2);
		rdc(arf_pkg::ADR_GP32 + 6'h5, 32'h00000202);
		seg(3'h3, 16'h1234, 32'h0, 32'h0);
		rdc(arf_pkg::ADR_BASE + 6'h3, 32'h00012340);
		mem(3'h3, 32'h00000010, 32'h00012350, 1'b0);
		mem(3'h3, 32'h00010000, 32'h00022340, 1'b1);
		protMode <= 1'b1;
		seg(3'h4, 16'h0008, 32'h00400000, 32'h00000fff);
		rdc(arf_pkg::ADR_LIMIT + 6'h4, 32'h00000fff);
		mem(3'h4, 32'h00001000, 32'h00401000, 1'b1);
		wr(arf_pkg::ADR_FLAGS, 32'h00000202);
		ext_irq_pin <= 1'b1;
		#1 chk({31'h0, irqTake}, 32'h1);
		wr(arf_pkg::ADR_FLAGS, 32'h00000102);
		#1 chk({31'h0, irqTake}, 32'h0);
		ext_irq_pin <= 1'b0;
		done(1'b0, 1'b0, 32'h12345678);
		chk(sx, {24'h1, arf_pkg::EXC_DEBUG});
		wr(arf_pkg::ADR_FLAGS, 32'h00000002);
		addr16 <= 1'b1;
		#1 chk(fetchOffset, 32'h00005678);
		addr16 <= 1'b0;
		fop(arf_pkg::FP_POP, 32'h00010002);
		done(1'b0, 1'b0, 32'h0);
		rdc(arf_pkg::ADR_FLAGS, 32'h00000002);
		bkptMatch <= 1'b1;
		done(1'b0, 1'b0, 32'h0);
		chk(sx, 32'h0);
		done(1'b0, 1'b0, 32'h0);
		chk(sx, {24'h1, arf_pkg::EXC_DEBUG});
		bkptMatch <= 1'b0;
		current_priv_level <= 2'h3;
		fop(arf_pkg::FP_POP, 32'h00003202);
		rdc(arf_pkg::ADR_FLAGS, 32'h00000002);
		done(1'b0, 1'b1, 32'h0);
		chk(sx & 32'h200, 32'h200);
		current_priv_level <= 2'h0;
		fop(arf_pkg::FP_POP, 32'h00003202);
		rdc(arf_pkg::ADR_FLAGS, 32'h00003202);
		current_priv_level <= 2'h3;
		done(1'b0, 1'b1, 32'h0);
		chk(sx, 32'h0);
		current_priv_level <= 2'h0;
		fop(arf_pkg::FP_INTERRUPT_RETURN_INSTR, 32'h00020002);
		rd(arf_pkg::ADR_STAT);
		chk(v & 32'h4, 32'h4);
		chk(flagSaveImage & 32'h20000, 32'h20000);
		chk(flagPushImage & 32'h20000, 32'h0);
		done(1'b1, 1'b0, 32'h0);
		chk(sx, {24'h1, arf_pkg::EXC_GPF});
		fop(arf_pkg::FP_POP, 32'h00000002);
		rd(arf_pkg::ADR_STAT);
		chk(v & 32'h4, 32'h4);
		taskNested <= 1'b1;
		fop(arf_pkg::FP_TASK, 32'h00004002);
		rd(arf_pkg::ADR_STAT);
		chk(v & 32'h4, 32'h0);
		fop(arf_pkg::FP_INTERRUPT_RETURN_INSTR, 32'h00000002);
		chk({31'h0, snr}, 32'h1);
		fop(arf_pkg::FP_INTERRUPT_RETURN_INSTR, 32'h00000002);
		chk({31'h0, snr}, 32'h0);
		wrap_up();
	end
endmodule : tb_arf_core_regs
`default_nettype wire
